//--- include/dirm_map.vh
// Register numbers, frame offsets, field positions and timing counts of the
// four-channel digital input block. Included by every design file.
`ifndef DIRM_MAP_VH
`define DIRM_MAP_VH

// ****************************************
// Function models
// ****************************************
`define DIRM_MODEL_STANDARD 8'h00
`define DIRM_MODEL_COUNTER 8'h01
`define DIRM_MODEL_BUSCTRL 8'hFE

// ****************************************
// Register numbers (acyclic access)
// ****************************************
`define DIRM_REG_INPUT_STATE_BYTE 8'h00
`define DIRM_REG_EDGE_TALLY_ONE 8'h04
`define DIRM_REG_EDGE_TALLY_TWO 8'h06
`define DIRM_REG_EDGE_TALLY_THREE 8'h08
`define DIRM_REG_EDGE_TALLY_FOUR 8'h0A
`define DIRM_REG_TALLY_CLEAR_REQUESTS 8'h0C
`define DIRM_REG_EDGE_SELECT_SETTING 8'h0E
`define DIRM_REG_FILTER_DELAY_SETTING 8'h12

// ****************************************
// Fixed frame offsets (cyclic access)
// ****************************************
`define DIRM_OFS_STD_INPUT 4'h1
`define DIRM_OFS_CNT_INPUT 4'h1
`define DIRM_OFS_CNT_TALLY_ONE 4'h2
`define DIRM_OFS_CNT_TALLY_TWO 4'h4
`define DIRM_OFS_CNT_TALLY_THREE 4'h6
`define DIRM_OFS_CNT_TALLY_FOUR 4'h8
`define DIRM_OFS_CNT_CLEAR 4'h0
`define DIRM_OFS_BUS_INPUT 4'h0

// ****************************************
// Field positions
// ****************************************
`define DIRM_EDGE_RISE_LSB 0
`define DIRM_EDGE_FALL_LSB 4

// ****************************************
// Reset values
// ****************************************
`define DIRM_RST_FILTER 8'h00
`define DIRM_RST_EDGE 8'h00
`define DIRM_RST_CLEAR 8'h00
`define DIRM_RST_TALLY 16'h0000

// ****************************************
// Timing
// ****************************************
`define DIRM_CLK_MHZ 25
`define DIRM_UNIT_US 100
`define DIRM_UNIT_CYCLES (`DIRM_UNIT_US * `DIRM_CLK_MHZ)
`define DIRM_SAMPLE_US 200
`define DIRM_SAMPLE_CYCLES (`DIRM_SAMPLE_US * `DIRM_CLK_MHZ)
`define DIRM_FILTER_MAX 8'hFA
`define DIRM_LED_TICK_MS 100
`define DIRM_LED_TICK_CYCLES (`DIRM_LED_TICK_MS * 1000 * `DIRM_CLK_MHZ)

`endif

//--- logic/dirm_filter.v
// One channel glitch filter: samples the pin on the sample enable and
// passes a new level only after it stood for the configured delay.
// Assumes unitTick and sampleTick are one-cycle enables from the top level.
`timescale 1ns/1ps
`default_nettype none
`include "dirm_map.vh"

module dirm_filter (
  input wire clk,
  input wire srst,
  input wire unitTick,
  input wire sampleTick,
  input wire rawIn,
  input wire [7:0] delayUnits,
  output reg levelOut
);

  reg sampled_reg;
  reg [7:0] stable_reg;

  // ****************************************
  // Sampling and debounce
  // ****************************************
  always @(posedge clk) begin
    if (srst) begin
      sampled_reg <= 1'b0;
      stable_reg <= 8'h00;
      levelOut <= 1'b0;
    end else begin
      if (sampleTick) begin
        sampled_reg <= rawIn;
      end
      if (delayUnits == 8'h00) begin
        levelOut <= sampled_reg;
        stable_reg <= 8'h00;
      end else if (sampled_reg == levelOut) begin
        stable_reg <= 8'h00;
      end else if (unitTick) begin
        // One extra tick, since the unit divider runs free
        if (stable_reg >= delayUnits) begin
          levelOut <= sampled_reg;
          stable_reg <= 8'h00;
        end else begin
          stable_reg <= stable_reg + 8'h01;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- logic/dirm_top.v
// Top of the four-channel digital input block: filters, edge tallies,
// cyclic frame and acyclic register access, and the status indicators.
// Assumes all inputs are synchronous to clk and the station drives one
// access per strobe.
`timescale 1ns/1ps
`default_nettype none
`include "dirm_map.vh"

module dirm_top #(
  parameter CHANNELS = 4,
  parameter SAMPLE_CYCLES = `DIRM_SAMPLE_CYCLES,
  parameter LED_TICK_CYCLES = `DIRM_LED_TICK_CYCLES
) (
  input wire clk,
  input wire srst,
  input wire [3:0] chanIn,
  input wire [7:0] funcModel,
  input wire cycRdEn,
  input wire [3:0] cycRdOffset,
  output reg [7:0] cycRdData,
  output reg cycRdValid,
  input wire cycWrEn,
  input wire [3:0] cycWrOffset,
  input wire [7:0] cycWrData,
  input wire acWrEn,
  input wire [7:0] acWrReg,
  input wire [7:0] acWrData,
  output reg acWrAck,
  output reg acWrErr,
  input wire supplyOk,
  input wire faultPresent,
  input wire [1:0] opMode,
  output reg runLed,
  output reg errLed,
  output reg [3:0] chanLed
);

  localparam integer UNIT_LAST_I = `DIRM_UNIT_CYCLES - 1;
  localparam integer SAMPLE_LAST_I = SAMPLE_CYCLES - 1;
  localparam integer LED_LAST_I = LED_TICK_CYCLES - 1;
  localparam [12:0] UNIT_LAST = UNIT_LAST_I[12:0];
  localparam [12:0] SAMPLE_LAST = SAMPLE_LAST_I[12:0];
  localparam [23:0] LED_LAST = LED_LAST_I[23:0];
  localparam [1:0] MODE_OFF = 2'b00;
  localparam [1:0] MODE_RESET = 2'b01;
  localparam [1:0] MODE_PREOP = 2'b10;
  localparam [1:0] MODE_RUN = 2'b11;

  reg [12:0] unitDiv_reg;
  reg [12:0] sampleDiv_reg;
  reg [23:0] ledDiv_reg;
  reg [2:0] ledPhase_reg;
  reg [7:0] filterSetting_reg;
  reg [7:0] edgeSelect_reg;
  reg [7:0] clearReq_reg;
  reg [7:0] clearPrev_reg;
  reg [3:0] levelPrev_reg;
  wire [CHANNELS*16-1:0] tallyAll;
  wire [1:0] tallyIdx;
  wire [15:0] tallyWord;
  wire unitTick;
  wire sampleTick;
  wire ledTick;
  wire [3:0] level;
  wire [7:0] delayUnits;
  wire [7:0] inputByte;

  // ****************************************
  // Frame decode helpers
  // ****************************************
  function isCounterModel;
    input [7:0] model;
    begin
      isCounterModel = (model == `DIRM_MODEL_COUNTER);
    end
  endfunction

  function isStandardModel;
    input [7:0] model;
    begin
      isStandardModel = (model == `DIRM_MODEL_STANDARD);
    end
  endfunction

  function isBusModel;
    input [7:0] model;
    begin
      isBusModel = (model == `DIRM_MODEL_BUSCTRL);
    end
  endfunction

  function [15:0] tallyAt;
    input [CHANNELS*16-1:0] all;
    input [1:0] idx;
    begin
      tallyAt = all[idx*16 +: 16];
    end
  endfunction

  // ****************************************
  // Filter unit timebase
  // ****************************************
  assign unitTick = (unitDiv_reg == UNIT_LAST);

  always @(posedge clk) begin
    if (srst) begin
      unitDiv_reg <= 13'h0000;
    end else begin
      unitDiv_reg <= unitTick ? 13'h0000 : unitDiv_reg + 13'h0001;
    end
  end

  // ****************************************
  // Pin sampling timebase
  // ****************************************
  assign sampleTick = (sampleDiv_reg == SAMPLE_LAST);

  always @(posedge clk) begin
    if (srst) begin
      sampleDiv_reg <= 13'h0000;
    end else begin
      sampleDiv_reg <= sampleTick ? 13'h0000 : sampleDiv_reg + 13'h0001;
    end
  end

  // ****************************************
  // Indicator timebase and flash phase
  // ****************************************
  assign ledTick = (ledDiv_reg == LED_LAST);

  always @(posedge clk) begin
    if (srst) begin
      ledDiv_reg <= 24'h000000;
      ledPhase_reg <= 3'h0;
    end else begin
      ledDiv_reg <= ledTick ? 24'h000000 : ledDiv_reg + 24'h000001;
      if (ledTick) begin
        ledPhase_reg <= ledPhase_reg + 3'h1;
      end
    end
  end

  // ****************************************
  // Channel filters
  // ****************************************
  assign delayUnits = (filterSetting_reg > `DIRM_FILTER_MAX) ?
    `DIRM_FILTER_MAX : filterSetting_reg;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : gChan
      dirm_filter uFilter (
        .clk(clk),
        .srst(srst),
        .unitTick(unitTick),
        .sampleTick(sampleTick),
        .rawIn(chanIn[ch]),
        .delayUnits(delayUnits),
        .levelOut(level[ch])
      );
    end
  endgenerate

  assign inputByte = {4'h0, level};

  // ****************************************
  // Acyclic register writes
  // ****************************************
  always @(posedge clk) begin
    if (srst) begin
      filterSetting_reg <= `DIRM_RST_FILTER;
      edgeSelect_reg <= `DIRM_RST_EDGE;
      acWrAck <= 1'b0;
      acWrErr <= 1'b0;
    end else begin
      acWrAck <= 1'b0;
      acWrErr <= 1'b0;
      if (acWrEn) begin
        if (acWrReg == `DIRM_REG_FILTER_DELAY_SETTING) begin
          filterSetting_reg <= acWrData;
          acWrAck <= 1'b1;
        end else if (acWrReg == `DIRM_REG_EDGE_SELECT_SETTING &&
                     isCounterModel(funcModel)) begin
          edgeSelect_reg <= acWrData;
          acWrAck <= 1'b1;
        end else begin
          acWrErr <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Cyclic clear requests
  // ****************************************
  always @(posedge clk) begin
    if (srst) begin
      clearReq_reg <= `DIRM_RST_CLEAR;
      clearPrev_reg <= `DIRM_RST_CLEAR;
    end else begin
      clearPrev_reg <= clearReq_reg;
      if (cycWrEn && isCounterModel(funcModel) &&
          cycWrOffset == `DIRM_OFS_CNT_CLEAR) begin
        clearReq_reg <= cycWrData;
      end
    end
  end

  // ****************************************
  // Edge tallies
  // ****************************************
  always @(posedge clk) begin
    if (srst) begin
      levelPrev_reg <= 4'h0;
    end else begin
      levelPrev_reg <= level;
    end
  end

  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1) begin : gTally
      wire riseHit;
      wire fallHit;
      wire clearHit;
      reg [15:0] tally_reg;
      assign riseHit = level[ch] & ~levelPrev_reg[ch] &
        edgeSelect_reg[`DIRM_EDGE_RISE_LSB + ch];
      assign fallHit = ~level[ch] & levelPrev_reg[ch] &
        edgeSelect_reg[`DIRM_EDGE_FALL_LSB + ch];
      assign clearHit = clearReq_reg[ch] & ~clearPrev_reg[ch];
      always @(posedge clk) begin
        if (srst) begin
          tally_reg <= `DIRM_RST_TALLY;
        end else if (clearHit) begin
          tally_reg <= `DIRM_RST_TALLY;
        end else if (riseHit | fallHit) begin
          tally_reg <= tally_reg + 16'h0001;
        end
      end
      assign tallyAll[ch*16 +: 16] = tally_reg;
    end
  endgenerate

  // ****************************************
  // Tally word select
  // ****************************************
  assign tallyIdx = cycRdOffset[2:1] - 2'h1;
  assign tallyWord = tallyAt(tallyAll, tallyIdx);

  // ****************************************
  // Cyclic frame reads
  // ****************************************
  always @(posedge clk) begin
    if (srst) begin
      cycRdData <= 8'h00;
      cycRdValid <= 1'b0;
    end else begin
      cycRdValid <= 1'b0;
      cycRdData <= 8'h00;
      if (cycRdEn) begin
        if (isStandardModel(funcModel)) begin
          if (cycRdOffset == `DIRM_OFS_STD_INPUT) begin
            cycRdData <= inputByte;
            cycRdValid <= 1'b1;
          end
        end else if (isCounterModel(funcModel)) begin
          if (cycRdOffset == `DIRM_OFS_CNT_INPUT) begin
            cycRdData <= inputByte;
            cycRdValid <= 1'b1;
          end else if (cycRdOffset >= `DIRM_OFS_CNT_TALLY_ONE &&
                       cycRdOffset <= `DIRM_OFS_CNT_TALLY_FOUR + 4'h1) begin
            cycRdData <= cycRdOffset[0] ? tallyWord[15:8] : tallyWord[7:0];
            cycRdValid <= 1'b1;
          end
        end else if (isBusModel(funcModel)) begin
          if (cycRdOffset == `DIRM_OFS_BUS_INPUT) begin
            cycRdData <= inputByte;
            cycRdValid <= 1'b1;
          end
        end
      end
    end
  end

  // ****************************************
  // Status indicators
  // ****************************************
  always @(posedge clk) begin
    if (srst) begin
      errLed <= 1'b0;
      chanLed <= 4'h0;
    end else begin
      chanLed <= level;
      errLed <= supplyOk & faultPresent;
    end
  end

  // ****************************************
  // Run indicator pattern
  // ****************************************
  always @(posedge clk) begin
    if (srst) begin
      runLed <= 1'b0;
    end else begin
      case (opMode)
        MODE_OFF: runLed <= 1'b0;
        MODE_RESET: runLed <= (ledPhase_reg == 3'h0);
        MODE_PREOP: runLed <= ledPhase_reg[0];
        MODE_RUN: runLed <= 1'b1;
        default: runLed <= 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- sim/digital_input_register_map_bench.sv
// Self-checking bench of the digital input block.
// Assumes short sample and indicator counts to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin fails++; \
  $display("mismatch %0t %s", $time, m); end end
module digital_input_register_map_bench;
  logic clk, srst, supplyOk, faultPresent, cycRdEn, cycRdValid, cycWrEn;
  logic acWrEn, acWrAck, acWrErr, runLed, errLed, v, ak, er;
  logic [1:0] opMode;
  logic [3:0] chanIn, cycRdOffset, cycWrOffset, chanLed;
  logic [7:0] funcModel, cycRdData, cycWrData, acWrReg, acWrData, d;
  logic [15:0] t;
  int fails = 0;
  int n_compared = 0;
  dirm_top #(.SAMPLE_CYCLES(20), .LED_TICK_CYCLES(16)) i_dut (.clk, .srst, .chanIn, .funcModel,
    .cycRdEn, .cycRdOffset, .cycRdData, .cycRdValid, .cycWrEn, .cycWrOffset, .cycWrData,
    .acWrEn, .acWrReg, .acWrData, .acWrAck, .acWrErr, .supplyOk, .faultPresent, .opMode,
    .runLed, .errLed, .chanLed);
  dirm_station i_sta (.clk, .cycRdEn, .cycRdOffset, .cycRdData, .cycRdValid, .cycWrEn,
    .cycWrOffset, .cycWrData, .acWrEn, .acWrReg, .acWrData, .acWrAck, .acWrErr);
  // ****************************************
  // Helpers
  // ****************************************
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rdc(input logic [3:0] o, input logic [7:0] e, input logic ve);
    i_sta.rd(o, d, v);
    `CHK(v, ve, "read valid")
    `CHK(d, e, "read data")
  endtask
  task automatic ac(input logic [7:0] r, input logic [7:0] x, input logic a);
    i_sta.ac(r, x, ak, er);
    `CHK(ak, a, "write ack")
    `CHK(er, ~a, "write error")
  endtask
  task automatic tally(input int n, input logic [15:0] e);
    i_sta.rd(4'(2 * n), t[7:0], v);
    i_sta.rd(4'(2 * n + 1), t[15:8], v);
    `CHK(t, e, "tally")
  endtask
  task automatic tog(input logic [3:0] m, input int n);
    repeat (n) begin
      chanIn <= chanIn ^ m;
      w(30);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_std();
    chanIn <= 4'hA;
    w(30);
    rdc(4'h1, 8'h0A, 1'b1);
    `CHK(chanLed, 4'hA, "channel leds")
    rdc(4'h2, 8'h00, 1'b0);
    $display("test standard done");
  endtask
  task automatic t_filter();
    ac(8'h12, 8'h02, 1'b1);
    ac(8'h00, 8'h05, 1'b0);
    chanIn <= 4'hB;
    w(60);
    chanIn <= 4'hA;
    w(6000);
    rdc(4'h1, 8'h0A, 1'b1);
    chanIn <= 4'hB;
    w(2000);
    rdc(4'h1, 8'h0A, 1'b1);
    w(6000);
    rdc(4'h1, 8'h0B, 1'b1);
    ac(8'h12, 8'h00, 1'b1);
    w(30);
    $display("test filter done");
  endtask
  task automatic t_count();
    funcModel <= 8'h01;
    ac(8'h0E, 8'h13, 1'b1);
    tog(4'hF, 4);
    tally(1, 16'h0004);
    tally(2, 16'h0002);
    tally(3, 16'h0000);
    tally(4, 16'h0000);
    i_sta.wr(4'h0, 8'h01);
    w(3);
    tally(1, 16'h0000);
    tally(2, 16'h0002);
    tog(4'h1, 2);
    i_sta.wr(4'h0, 8'h01);
    w(3);
    tally(1, 16'h0002);
    $display("test counter done");
  endtask
  task automatic t_bus();
    int hi;
    funcModel <= 8'hFE;
    rdc(4'h0, 8'h0B, 1'b1);
    rdc(4'h1, 8'h00, 1'b0);
    ac(8'h0E, 8'h00, 1'b0);
    faultPresent <= 1'b1;
    w(3);
    `CHK(errLed, 1'b1, "error led lit")
    supplyOk <= 1'b0;
    w(3);
    `CHK(errLed, 1'b0, "error led no supply")
    opMode <= 2'h0;
    w(3);
    `CHK(runLed, 1'b0, "run led off")
    opMode <= 2'h2;
    w(3);
    v = runLed;
    w(16);
    `CHK(runLed, ~v, "run led blink")
    opMode <= 2'h1;
    w(3);
    hi = 0;
    repeat (128) begin
      w(1);
      hi += runLed;
    end
    `CHK(hi, 16, "run led flash")
    opMode <= 2'h3;
    w(3);
    `CHK(runLed, 1'b1, "run led on")
    $display("test bus and leds done");
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #1000000;
    fails++;
    $display("mismatch %0t watchdog", $time);
    give_verdict();
  end
  initial begin
    srst = 1'b1;
    chanIn = 4'h0;
    funcModel = 8'h00;
    supplyOk = 1'b1;
    faultPresent = 1'b0;
    opMode = 2'h3;
    w(2);
    srst <= 1'b0;
    w(1);
    t_std();
    t_filter();
    t_count();
    t_bus();
    give_verdict();
  end
endmodule
`default_nettype wire

//--- sim/dirm_asserts.sv
// Port checks of the digital input block top.
// Assumes the single clock and synchronous reset of the top level.
`timescale 1ns/1ps
`default_nettype none
module dirm_asserts (
  input wire clk,
  input wire srst,
  input wire [7:0] funcModel,
  input wire cycRdEn,
  input wire [3:0] cycRdOffset,
  input wire [7:0] cycRdData,
  input wire cycRdValid,
  input wire acWrEn,
  input wire [7:0] acWrReg,
  input wire acWrAck,
  input wire acWrErr,
  input wire supplyOk,
  input wire faultPresent,
  input wire errLed,
  input wire [1:0] opMode,
  input wire runLed
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);
  chk_std_read: assert property (
    cycRdEn && funcModel == 8'h00 && cycRdOffset == 4'h1 |=> cycRdValid && !cycRdData[7:4])
    else $error("standard read");
  chk_std_refuse: assert property (
    cycRdEn && funcModel == 8'h00 && cycRdOffset != 4'h1 |=> !cycRdValid && cycRdData == 8'h00)
    else $error("standard refuse");
  chk_tally_read: assert property (
    cycRdEn && funcModel == 8'h01 && cycRdOffset inside {[1:9]} |=> cycRdValid)
    else $error("tally read");
  chk_bus_read: assert property (
    cycRdEn && funcModel == 8'hFE |=> cycRdValid == ($past(cycRdOffset) == 4'h0))
    else $error("bus read");
  chk_read_quiet: assert property (
    !cycRdEn |=> !cycRdValid && cycRdData == 8'h00)
    else $error("read quiet");
  chk_filter_ack: assert property (
    acWrEn && acWrReg == 8'h12 |=> acWrAck && !acWrErr)
    else $error("filter ack");
  chk_edge_ack: assert property (
    acWrEn && acWrReg == 8'h0E |=> acWrAck == ($past(funcModel) == 8'h01) && acWrErr != acWrAck)
    else $error("edge ack");
  chk_other_refuse: assert property (
    acWrEn && acWrReg != 8'h12 && acWrReg != 8'h0E |=> acWrErr && !acWrAck)
    else $error("register refuse");
  chk_err_dark: assert property (
    !supplyOk || !faultPresent |=> !errLed)
    else $error("error led");
  chk_run_on: assert property (
    opMode == 2'h3 |=> runLed)
    else $error("run led on");
  chk_run_off: assert property (
    opMode == 2'h0 |=> !runLed)
    else $error("run led off");
endmodule
bind dirm_top dirm_asserts i_chk (.clk, .srst, .funcModel, .cycRdEn, .cycRdOffset, .cycRdData,
  .cycRdValid, .acWrEn, .acWrReg, .acWrAck, .acWrErr, .supplyOk, .faultPresent, .errLed,
  .opMode, .runLed);
`default_nettype wire

//--- sim/dirm_station.sv
// Controlling station model: cyclic reads and writes, acyclic writes.
// Assumes its tasks are called one at a time from a clock edge.
`timescale 1ns/1ps
`default_nettype none
module dirm_station (
  input wire logic clk,
  output logic cycRdEn,
  output logic [3:0] cycRdOffset,
  input wire logic [7:0] cycRdData,
  input wire logic cycRdValid,
  output logic cycWrEn,
  output logic [3:0] cycWrOffset,
  output logic [7:0] cycWrData,
  output logic acWrEn,
  output logic [7:0] acWrReg,
  output logic [7:0] acWrData,
  input wire logic acWrAck,
  input wire logic acWrErr
);
  initial begin
    cycRdEn = 1'b0;
    cycWrEn = 1'b0;
    acWrEn = 1'b0;
    cycRdOffset = 4'h0;
    cycWrOffset = 4'h0;
    cycWrData = 8'h00;
    acWrReg = 8'h00;
    acWrData = 8'h00;
  end
  // Strobe held over one edge; answer taken one edge later
  task automatic rd(input logic [3:0] o, output logic [7:0] d, output logic v);
    @(posedge clk);
    cycRdEn <= 1'b1;
    cycRdOffset <= o;
    @(posedge clk);
    cycRdEn <= 1'b0;
    cycRdOffset <= ~o;
    @(posedge clk);
    d = cycRdData;
    v = cycRdValid;
  endtask
  task automatic wr(input logic [3:0] o, input logic [7:0] x);
    @(posedge clk);
    cycWrEn <= 1'b1;
    cycWrOffset <= o;
    cycWrData <= x;
    @(posedge clk);
    cycWrEn <= 1'b0;
    cycWrOffset <= ~o;
    cycWrData <= ~x;
  endtask
  task automatic ac(input logic [7:0] r, input logic [7:0] x, output logic a, output logic e);
    @(posedge clk);
    acWrEn <= 1'b1;
    acWrReg <= r;
    acWrData <= x;
    @(posedge clk);
    acWrEn <= 1'b0;
    acWrReg <= ~r;
    acWrData <= ~x;
    @(posedge clk);
    a = acWrAck;
    e = acWrErr;
  endtask
endmodule
`default_nettype wire
